// File: logic/framer_params.svh
/*
 Constants of the host-port message framing: start byte, packet types,
 lengths, status codes, roles and payload limits.
 Assumes inclusion by the package and both ends.
*/
`ifndef FRAMER_PARAMS_SVH
`define FRAMER_PARAMS_SVH
`define SOP_BYTE      8'hFB
`define T_RD_REQ      8'h06
`define T_WR_REQ      8'h07
`define T_RD_RSP      8'h16
`define T_WR_RSP      8'h17
`define T_RX_EVT      8'h26
`define T_NOTICE      8'h27
`define LEN_RD_REQ    8'h07
`define LEN_REQ_BASE  8'h07
`define LEN_RSP_SHORT 8'h06
`define LEN_RD_OK     8'h09
`define LEN_NOTICE    8'h02
`define LEN_EVT_HDR   8'h05
`define ST_OK         8'h00
`define ST_BAD_ARG    8'hE1
`define ST_INIT_DONE  8'hA0
`define ST_RO_WRITE   8'hE4
`define ST_BROWNOUT   8'hEC
`define ST_WATCHDOG   8'hED
`define ST_HW_FAULT   8'hEE
`define ROLE_BASE     2'h1
`define LIM_BASE      8'h69
`define LIM_OTHER     8'h6D
`define MAX_VAL       8'h10
`define RSSI_BAD      8'h7F
`define RSSI_TOP      8'h7E
`define RBUF_DEPTH    23
`define FIFO_DEPTH    4
`endif

// File: logic/framer_pkg.sv
/*
 Types shared by both ends of the host-port framer.
 Assumes framer_params.svh on the include path.
*/
`include "framer_params.svh"
package framer_pkg;
   typedef enum logic [2:0] {R_SOP, R_LEN, R_BODY, R_DEC, R_WAIT} rx_state_t;
   typedef enum logic [1:0] {T_IDLE, T_SEND, T_DROP} tx_state_t;
   typedef enum logic [1:0] {K_NOTE, K_REP, K_EV} msg_kind_t;
   function automatic logic [7:0] rssi_code(input logic [7:0] r, input logic ok);
      // 127 is reserved for an invalid measurement, so a true 127 saturates
      rssi_code = !ok ? `RSSI_BAD : ((r == `RSSI_BAD) ? `RSSI_TOP : r);
   endfunction: rssi_code
endpackage: framer_pkg

// File: logic/host_link_if.sv
/*
 Byte-stream link between host processor and device framer.
 Assumes both ends on clk_sys; each direction is valid/ready.
*/
`timescale 1ns/1ps
interface host_link_if;
   logic       h2d_valid;
   logic [7:0] h2d_data;
   logic       h2d_ready;
   logic       d2h_valid;
   logic [7:0] d2h_data;
   logic       d2h_ready;
   modport dev  (input h2d_valid, h2d_data, d2h_ready,
                 output h2d_ready, d2h_valid, d2h_data);
   modport host (output h2d_valid, h2d_data, d2h_ready,
                 input h2d_ready, d2h_valid, d2h_data);
endinterface: host_link_if

// File: logic/framer_dev.sv
/*
 Device end: parses far-node read/write commands from the host, hands them
 to the radio side, frames replies, received-payload events and notices.
 Assumes one clock clk_sys, the radio side on the same clock.
*/
`timescale 1ns/1ps
module byte_fifo #(parameter int WIDTH = 8, parameter int DEPTH = 4) (
   // system
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // fill side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready_q,
   // drain side
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wp_q, rp_q;
   logic [AW:0]      cnt_q, cnt_d;
   wire push = in_valid & in_ready_q;
   wire pop  = out_valid & out_ready;
   assign out_valid = cnt_q != '0;
   assign out_data  = mem_q[rp_q];
   assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   always_ff @(posedge clk_sys) begin
      if (push) mem_q[wp_q] <= in_data;
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wp_q <= '0; rp_q <= '0; cnt_q <= '0; in_ready_q <= 1'b0;
      end else begin
         wp_q       <= wp_q + AW'(push);
         rp_q       <= rp_q + AW'(pop);
         cnt_q      <= cnt_d;
         in_ready_q <= cnt_d != (AW+1)'(DEPTH);
      end
   end
endmodule: byte_fifo

module framer_dev import framer_pkg::*; (
   // system
   input  wire logic         clk_sys,
   input  wire logic         rst,
   // host link
   host_link_if.dev          lnk,
   // far-node request to radio side
   output logic              req_valid_q,
   input  wire logic         req_ready,
   output logic              req_write_q,
   output logic      [23:0]  req_addr_q,
   output logic      [7:0]   req_offset_q,
   output logic      [7:0]   req_bank_q,
   output logic      [7:0]   req_size_q,
   output logic      [127:0] req_value_q,
   // far-node answer from radio side
   input  wire logic         resp_valid,
   input  wire logic         resp_ok,
   input  wire logic [7:0]   resp_rssi,
   input  wire logic         resp_rssi_ok,
   input  wire logic [127:0] resp_value,
   // received payload event
   input  wire logic         ev_valid,
   output logic              ev_ack_q,
   input  wire logic [23:0]  ev_addr,
   input  wire logic [7:0]   ev_rssi,
   input  wire logic         ev_rssi_ok,
   input  wire logic [7:0]   ev_len,
   input  wire logic         pl_valid,
   input  wire logic [7:0]   pl_data,
   output logic              pl_ready_q,
   // role and notices
   input  wire logic [1:0]   node_role_select,
   input  wire logic         notice_valid,
   input  wire logic [7:0]   notice_code,
   output logic              notice_ack_q
);
   rx_state_t  rs_q, rs_d;
   tx_state_t  ts_q;
   msg_kind_t  kind_q;
   logic [7:0] rbuf_q [`RBUF_DEPTH];
   logic [7:0] rlen_q, rcnt_q, tlen_q, idx_q, note_q, drop_q, ev_n_q;
   logic [7:0] rep_st_q, rep_rssi_q, ev_rssi_q;
   logic [23:0] ev_addr_q;
   logic [127:0] rep_val_q;
   logic       rdy_q, rep_pend_q, dv_q;
   logic [7:0] dd_q;
   logic       f_valid, f_pop;
   logic [7:0] f_data, byte_w;

   byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .in_valid  (pl_valid),
      .in_data   (pl_data),
      .in_ready_q(pl_ready_q),
      .out_valid (f_valid),
      .out_data  (f_data),
      .out_ready (f_pop)
   );

   // receive side decode
   wire        take   = lnk.h2d_valid & rdy_q;
   wire        last   = rcnt_q == rlen_q - 8'h01;
   wire [7:0]  b_type = rbuf_q[0];
   wire [7:0]  b_size = rbuf_q[6];
   wire        is_rd  = b_type == `T_RD_REQ;
   wire        is_wr  = b_type == `T_WR_REQ;
   wire        sz_ok  = b_size != 8'h00 && b_size <= `MAX_VAL;
   wire        len_ok = is_rd ? rlen_q == `LEN_RD_REQ
                              : rlen_q == `LEN_REQ_BASE + b_size;
   wire        arg_ok = sz_ok & len_ok;
   wire        resp_in = resp_valid & (rs_q == R_WAIT) & !rep_pend_q & !req_valid_q;

   always_comb begin
      rs_d = rs_q;
      unique case (rs_q)
         R_SOP:  if (take && lnk.h2d_data == `SOP_BYTE) rs_d = R_LEN;
         R_LEN:  if (take) rs_d = (lnk.h2d_data == 8'h00) ? R_SOP : R_BODY;
         R_BODY: if (take && last) rs_d = R_DEC;
         R_DEC:  rs_d = (is_rd | is_wr) ? R_WAIT : R_SOP;
         // leave only when the transmit side really takes the reply, or it goes out twice
         R_WAIT: if (ts_q == T_IDLE && rep_pend_q && !(notice_valid && !notice_ack_q))
            rs_d = R_SOP;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rs_q == R_BODY && take && rcnt_q < 8'(`RBUF_DEPTH))
         rbuf_q[rcnt_q[4:0]] <= lnk.h2d_data;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rs_q <= R_SOP; rdy_q <= 1'b0; rlen_q <= 8'h00; rcnt_q <= 8'h00;
      end else begin
         rs_q  <= rs_d;
         rdy_q <= rs_d == R_SOP || rs_d == R_LEN || rs_d == R_BODY;
         if (rs_q == R_LEN && take) rlen_q <= lnk.h2d_data;
         rcnt_q <= (rs_q == R_BODY) ? rcnt_q + 8'(take) : 8'h00;
      end
   end

   // request out and answer in
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         req_valid_q <= 1'b0; req_write_q <= 1'b0; req_addr_q <= '0;
         req_offset_q <= '0; req_bank_q <= '0; req_size_q <= '0;
         req_value_q <= '0; rep_pend_q <= 1'b0; rep_st_q <= `ST_OK;
         rep_rssi_q <= `RSSI_BAD; rep_val_q <= '0;
      end else begin
         if (req_valid_q && req_ready) req_valid_q <= 1'b0;
         if (rs_q == R_DEC && (is_rd | is_wr)) begin
            req_write_q  <= is_wr;
            req_addr_q   <= {rbuf_q[3], rbuf_q[2], rbuf_q[1]};
            req_offset_q <= rbuf_q[4];
            req_bank_q   <= rbuf_q[5];
            req_size_q   <= b_size;
            for (int k = 0; k < 16; k++)
               req_value_q[8*k +: 8] <= rbuf_q[7+k];
            req_valid_q  <= arg_ok;
            rep_pend_q   <= !arg_ok;
            rep_st_q     <= arg_ok ? `ST_OK : `ST_BAD_ARG;
            rep_rssi_q   <= `RSSI_BAD;
         end
         if (resp_in) begin
            rep_pend_q <= 1'b1;
            rep_st_q   <= resp_ok ? `ST_OK : `ST_BAD_ARG;
            rep_rssi_q <= rssi_code(resp_rssi, resp_rssi_ok);
            rep_val_q  <= resp_value;
         end
         if (rs_q == R_WAIT && rs_d == R_SOP) rep_pend_q <= 1'b0;
      end
   end

   // transmit side: byte at current index
   wire [7:0] j     = idx_q - 8'h02;
   wire [3:0] vi    = 4'(j - `LEN_RD_OK);
   wire       rep_ok = rep_st_q == `ST_OK;
   wire [7:0] rep_b =
      (j == 8'h00) ? (req_write_q ? `T_WR_RSP : `T_RD_RSP) :
      (j == 8'h01) ? rep_st_q :
      (j == 8'h02) ? req_addr_q[7:0] :
      (j == 8'h03) ? req_addr_q[15:8] :
      (j == 8'h04) ? req_addr_q[23:16] :
      (j == 8'h05) ? rep_rssi_q :
      (j == 8'h06) ? req_offset_q :
      (j == 8'h07) ? req_bank_q :
      (j == 8'h08) ? req_size_q : rep_val_q[8*vi +: 8];
   wire [7:0] ev_b  =
      (j == 8'h00) ? `T_RX_EVT :
      (j == 8'h01) ? ev_addr_q[7:0] :
      (j == 8'h02) ? ev_addr_q[15:8] :
      (j == 8'h03) ? ev_addr_q[23:16] :
      (j == 8'h04) ? ev_rssi_q : f_data;
   wire [7:0] note_b = (j == 8'h00) ? `T_NOTICE : note_q;
   assign byte_w = (idx_q == 8'h00) ? `SOP_BYTE :
                   (idx_q == 8'h01) ? tlen_q :
                   (kind_q == K_REP) ? rep_b :
                   (kind_q == K_EV) ? ev_b : note_b;

   wire       adv     = !dv_q | lnk.d2h_ready;
   wire       need_pl = kind_q == K_EV && idx_q >= 8'h07;
   wire       can     = !need_pl | f_valid;
   wire       load    = ts_q == T_SEND && adv && can;
   assign f_pop = f_valid & ((load & need_pl) | (ts_q == T_DROP));
   wire note_legal = notice_code == `ST_INIT_DONE || notice_code == `ST_BAD_ARG ||
                     notice_code == `ST_RO_WRITE || notice_code == `ST_BROWNOUT ||
                     notice_code == `ST_WATCHDOG || notice_code == `ST_HW_FAULT;
   wire [7:0] lim   = (node_role_select == `ROLE_BASE) ? `LIM_BASE : `LIM_OTHER;
   wire [7:0] ev_nw = (ev_len > lim) ? lim : ev_len;
   // a short failed read reply drops offset, bank, size and value
   wire [7:0] rep_len = (req_write_q || !rep_ok) ? `LEN_RSP_SHORT
                                                 : `LEN_RD_OK + req_size_q;
   wire       idle  = ts_q == T_IDLE;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ts_q <= T_IDLE; kind_q <= K_NOTE; tlen_q <= 8'h00; idx_q <= 8'h00;
         note_q <= 8'h00; drop_q <= 8'h00; ev_n_q <= 8'h00;
         ev_addr_q <= '0; ev_rssi_q <= `RSSI_BAD;
         dv_q <= 1'b0; dd_q <= 8'h00; notice_ack_q <= 1'b0; ev_ack_q <= 1'b0;
      end else begin
         notice_ack_q <= 1'b0;
         ev_ack_q     <= 1'b0;
         if (adv && !load) dv_q <= 1'b0;
         unique case (ts_q)
            T_IDLE: begin
               idx_q <= 8'h00;
               // notices win: they report faults and must not wait on traffic
               if (notice_valid && !notice_ack_q) begin
                  notice_ack_q <= 1'b1;
                  if (note_legal) begin
                     kind_q <= K_NOTE; tlen_q <= `LEN_NOTICE;
                     note_q <= notice_code; ts_q <= T_SEND;
                  end
               end else if (rep_pend_q && rs_q == R_WAIT) begin
                  kind_q <= K_REP; tlen_q <= rep_len; ts_q <= T_SEND;
               end else if (ev_valid && !ev_ack_q) begin
                  ev_ack_q  <= 1'b1;
                  kind_q    <= K_EV;
                  tlen_q    <= `LEN_EVT_HDR + ev_nw;
                  ev_n_q    <= ev_nw;
                  drop_q    <= ev_len - ev_nw;
                  ev_addr_q <= ev_addr;
                  ev_rssi_q <= rssi_code(ev_rssi, ev_rssi_ok);
                  ts_q      <= T_SEND;
               end
            end
            T_SEND: if (load) begin
               dv_q  <= 1'b1;
               dd_q  <= byte_w;
               idx_q <= idx_q + 8'h01;
               if (idx_q == tlen_q + 8'h01)
                  ts_q <= (kind_q == K_EV && drop_q != 8'h00) ? T_DROP : T_IDLE;
            end
            T_DROP: if (f_valid) begin
               drop_q <= drop_q - 8'h01;
               if (drop_q == 8'h01) ts_q <= T_IDLE;
            end
         endcase
      end
   end

   assign lnk.h2d_ready = rdy_q;
   assign lnk.d2h_valid = dv_q;
   assign lnk.d2h_data  = dd_q;
endmodule: framer_dev

// File: logic/framer_host.sv
/*
 Host end: frames far-node read and write commands and splits incoming
 messages into typed bytes for the host software.
 Assumes one clock clk_sys shared with the device end.
*/
`timescale 1ns/1ps
module framer_host import framer_pkg::*; (
   // system
   input  wire logic         clk_sys,
   input  wire logic         rst,
   // host link
   host_link_if.host         lnk,
   // command from host software
   input  wire logic         cmd_valid,
   output logic              cmd_ack_q,
   input  wire logic         cmd_write,
   input  wire logic [23:0]  cmd_addr,
   input  wire logic [7:0]   cmd_offset,
   input  wire logic [7:0]   cmd_bank,
   input  wire logic [7:0]   cmd_size,
   input  wire logic [127:0] cmd_value,
   // incoming message bytes
   output logic              rx_byte_valid_q,
   output logic      [7:0]   rx_byte_q,
   output logic      [7:0]   rx_pos_q,
   output logic              msg_done_q,
   output logic      [7:0]   msg_type_q,
   output logic      [7:0]   msg_len_q,
   output logic      [23:0]  msg_addr_q
);
   tx_state_t   ts_q;
   rx_state_t   rs_q;
   logic        wr_q, dv_q, rdy_q;
   logic [7:0]  dd_q, idx_q, len_q, off_q, bank_q, size_q, cnt_q;
   logic [23:0] addr_q;
   logic [127:0] val_q;

   wire [7:0] j  = idx_q - 8'h02;
   wire [3:0] vi = 4'(j - `LEN_REQ_BASE);
   wire [7:0] byte_w =
      (idx_q == 8'h00) ? `SOP_BYTE :
      (idx_q == 8'h01) ? len_q :
      (j == 8'h00) ? (wr_q ? `T_WR_REQ : `T_RD_REQ) :
      (j == 8'h01) ? addr_q[7:0] :
      (j == 8'h02) ? addr_q[15:8] :
      (j == 8'h03) ? addr_q[23:16] :
      (j == 8'h04) ? off_q :
      (j == 8'h05) ? bank_q :
      (j == 8'h06) ? size_q : val_q[8*vi +: 8];
   wire adv  = !dv_q | lnk.h2d_ready;
   wire take = lnk.d2h_valid & rdy_q;
   wire [7:0] p = cnt_q;
   // reply addresses sit one byte later than the event's, behind the status
   wire evt  = msg_type_q == `T_RX_EVT;
   wire [7:0] a0 = evt ? 8'h01 : 8'h02;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ts_q <= T_IDLE; wr_q <= 1'b0; dv_q <= 1'b0; dd_q <= 8'h00;
         idx_q <= 8'h00; len_q <= 8'h00; off_q <= 8'h00; bank_q <= 8'h00;
         size_q <= 8'h00; addr_q <= '0; val_q <= '0; cmd_ack_q <= 1'b0;
      end else begin
         cmd_ack_q <= 1'b0;
         if (adv) dv_q <= 1'b0;
         unique case (ts_q)
            T_IDLE: begin
               idx_q <= 8'h00;
               if (cmd_valid && !cmd_ack_q) begin
                  cmd_ack_q <= 1'b1;
                  wr_q   <= cmd_write;
                  // a write carries exactly the register's size in value bytes
                  len_q  <= cmd_write ? `LEN_REQ_BASE + cmd_size
                                      : `LEN_RD_REQ;
                  addr_q <= cmd_addr; off_q <= cmd_offset;
                  bank_q <= cmd_bank; size_q <= cmd_size; val_q <= cmd_value;
                  ts_q   <= T_SEND;
               end
            end
            T_SEND: if (adv) begin
               dv_q  <= 1'b1;
               dd_q  <= byte_w;
               idx_q <= idx_q + 8'h01;
               if (idx_q == len_q + 8'h01) ts_q <= T_IDLE;
            end
            default: ts_q <= T_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rs_q <= R_SOP; rdy_q <= 1'b0; cnt_q <= 8'h00; rx_byte_valid_q <= 1'b0;
         rx_byte_q <= 8'h00; rx_pos_q <= 8'h00; msg_done_q <= 1'b0;
         msg_type_q <= 8'h00; msg_len_q <= 8'h00; msg_addr_q <= '0;
      end else begin
         rdy_q <= 1'b1;
         rx_byte_valid_q <= 1'b0;
         msg_done_q <= 1'b0;
         if (take) begin
            unique case (rs_q)
               R_SOP: if (lnk.d2h_data == `SOP_BYTE) rs_q <= R_LEN;
               R_LEN: begin
                  msg_len_q <= lnk.d2h_data;
                  cnt_q     <= 8'h00;
                  rs_q      <= (lnk.d2h_data == 8'h00) ? R_SOP : R_BODY;
               end
               R_BODY: begin
                  rx_byte_valid_q <= 1'b1;
                  rx_byte_q <= lnk.d2h_data;
                  rx_pos_q  <= p;
                  if (p == 8'h00) msg_type_q <= lnk.d2h_data;
                  if (p != 8'h00 && p == a0) msg_addr_q[7:0] <= lnk.d2h_data;
                  if (p != 8'h00 && p == a0 + 8'h01) msg_addr_q[15:8] <= lnk.d2h_data;
                  if (p != 8'h00 && p == a0 + 8'h02) msg_addr_q[23:16] <= lnk.d2h_data;
                  cnt_q <= p + 8'h01;
                  if (p == msg_len_q - 8'h01) begin
                     msg_done_q <= 1'b1;
                     rs_q <= R_SOP;
                  end
               end
               default: rs_q <= R_SOP;
            endcase
         end
      end
   end

   assign lnk.h2d_valid = dv_q;
   assign lnk.h2d_data  = dd_q;
   assign lnk.d2h_ready = rdy_q;
endmodule: framer_host

// File: tb/framer_properties.sv
/*
 Checker for the device-to-host byte stream of the host link.
 Assumes instantiation beside host_link_if, fed its signals as plain inputs.
*/
`timescale 1ns/1ps
module framer_properties (
   // system
   input wire logic       clk_sys,
   input wire logic       rst,
   // host link
   input wire logic       h2d_valid,
   input wire logic [7:0] h2d_data,
   input wire logic       h2d_ready,
   input wire logic       d2h_valid,
   input wire logic [7:0] d2h_data,
   input wire logic       d2h_ready
);
   logic [7:0] pos_q;
   logic [7:0] len_q;
   logic [7:0] typ_q;
   wire        tk = d2h_valid && d2h_ready;
   // zero length closes the frame at once, so the counter never waits for a body
   wire  [7:0] pos_d = (pos_q == 8'h00) ? 8'h01 :
                       (pos_q == 8'h01) ? ((d2h_data == 8'h00) ? 8'h00 : 8'h02) :
                       (pos_q == len_q + 8'h01) ? 8'h00 : pos_q + 8'h01;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pos_q <= 8'h00;
         len_q <= 8'h00;
         typ_q <= 8'h00;
      end else if (tk) begin
         pos_q <= pos_d;
         len_q <= (pos_q == 8'h01) ? d2h_data : len_q;
         typ_q <= (pos_q == 8'h02) ? d2h_data : typ_q;
      end
   end
   property p_sop;
      tk && pos_q == 8'h00 |-> d2h_data == 8'hFB;
   endproperty
   a_sop: assert property (p_sop) else $error("frame does not open with start byte");
   property p_type;
      tk && pos_q == 8'h02 |-> d2h_data inside {8'h16, 8'h17, 8'h26, 8'h27};
   endproperty
   a_type: assert property (p_type) else $error("unknown packet type sent");
   property p_wr_len;
      tk && pos_q == 8'h02 && d2h_data == 8'h17 |-> len_q == 8'h06;
   endproperty
   a_wr_len: assert property (p_wr_len) else $error("write reply length wrong");
   property p_note_len;
      tk && pos_q == 8'h02 && d2h_data == 8'h27 |-> len_q == 8'h02;
   endproperty
   a_note_len: assert property (p_note_len) else $error("notice length wrong");
   property p_note_code;
      tk && pos_q == 8'h03 && typ_q == 8'h27
         |-> d2h_data inside {8'hA0, 8'hE1, 8'hE4, 8'hEC, 8'hED, 8'hEE};
   endproperty
   a_note_code: assert property (p_note_code) else $error("notice code outside set");
   property p_status;
      tk && pos_q == 8'h03 && (typ_q == 8'h16 || typ_q == 8'h17)
         |-> d2h_data == 8'h00 || d2h_data == 8'hE1;
   endproperty
   a_status: assert property (p_status) else $error("reply status outside set");
   property p_rd_err;
      tk && pos_q == 8'h03 && typ_q == 8'h16 && d2h_data == 8'hE1 |-> len_q == 8'h06;
   endproperty
   a_rd_err: assert property (p_rd_err) else $error("failed read reply not shortened");
   property p_rd_ok;
      tk && pos_q == 8'h03 && typ_q == 8'h16 && d2h_data == 8'h00
         |-> len_q >= 8'h0A && len_q <= 8'h19;
   endproperty
   a_rd_ok: assert property (p_rd_ok) else $error("read reply length out of range");
   property p_ev_len;
      tk && pos_q == 8'h02 && d2h_data == 8'h26 |-> len_q >= 8'h05 && len_q <= 8'h72;
   endproperty
   a_ev_len: assert property (p_ev_len) else $error("event length out of range");
   property p_frame_end;
      tk && pos_q == len_q + 8'h01 && pos_q > 8'h01 |=> !d2h_valid;
   endproperty
   a_frame_end: assert property (p_frame_end) else $error("bytes run past frame length");
endmodule: framer_properties

// File: tb/remote_register_and_event_framer_bench.sv
/*
 Bench joining host and device framer ends over one link; drives commands,
 radio answers, events and notices, and compares wire bytes.
 Assumes the design files and framer_properties are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin bad_count++; \
   $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
`define WAIT_HI(s) begin wk = 0; while (!(s) && wk < 3000) begin @(negedge clk_sys); \
   wk++; end if (!(s)) begin bad_count++; $display("[FAIL] handshake expected 1 seen 0"); \
   end end
module remote_register_and_event_framer_bench import framer_pkg::*;;
   logic clk_sys, rst, cmd_valid, cmd_ack_q, cmd_write, req_valid_q, req_ready, req_write_q;
   logic [23:0] cmd_addr, req_addr_q, ev_addr, msg_addr_q;
   logic [7:0] cmd_offset, cmd_bank, cmd_size, req_offset_q, req_bank_q, req_size_q, msg_type_q;
   logic [127:0] cmd_value, req_value_q, resp_value;
   logic resp_valid, resp_ok, resp_rssi_ok, ev_valid, ev_ack_q, ev_rssi_ok, pl_valid, pl_ready_q;
   logic [7:0] resp_rssi, ev_rssi, ev_len, pl_data, notice_code, msg_len_q;
   logic [1:0] node_role_select;
   logic notice_valid, notice_ack_q;
   int bad_count, n_checks, cyc, wk;
   int exp[$];
   logic [7:0] wq[$], hq[$];
   logic [7:0] codes[6] = '{8'hA0, 8'hE1, 8'hE4, 8'hEC, 8'hED, 8'hEE};
   host_link_if lnk ();
   framer_host framer_host_inst (.clk_sys, .rst, .lnk(lnk), .cmd_valid, .cmd_ack_q, .cmd_write,
      .cmd_addr, .cmd_offset, .cmd_bank, .cmd_size, .cmd_value, .rx_byte_valid_q(), .rx_byte_q(),
      .rx_pos_q(), .msg_done_q(), .msg_type_q, .msg_len_q, .msg_addr_q);
   framer_dev framer_dev_inst (.clk_sys, .rst, .lnk(lnk), .req_valid_q, .req_ready, .req_write_q,
      .req_addr_q, .req_offset_q, .req_bank_q, .req_size_q, .req_value_q, .resp_valid, .resp_ok,
      .resp_rssi, .resp_rssi_ok, .resp_value, .ev_valid, .ev_ack_q, .ev_addr, .ev_rssi,
      .ev_rssi_ok, .ev_len, .pl_valid, .pl_data, .pl_ready_q, .node_role_select, .notice_valid,
      .notice_code, .notice_ack_q);
   framer_properties framer_properties_inst (.clk_sys, .rst, .h2d_valid(lnk.h2d_valid),
      .h2d_data(lnk.h2d_data), .h2d_ready(lnk.h2d_ready), .d2h_valid(lnk.d2h_valid),
      .d2h_data(lnk.d2h_data), .d2h_ready(lnk.d2h_ready));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask: end_of_test
   // wire bytes are captured where taken; design flops update after this read
   always @(posedge clk_sys) begin
      if (lnk.d2h_valid && lnk.d2h_ready) wq.push_back(lnk.d2h_data);
      if (lnk.h2d_valid && lnk.h2d_ready) hq.push_back(lnk.h2d_data);
      cyc++;
      if (cyc == 50000) begin
         bad_count++;
         end_of_test();
      end
   end
   // negative entries in exp are fields whose value is left to the design
   task automatic check_msg(input bit from_dev);
      int i;
      wk = 0;
      while (((from_dev ? wq.size() : hq.size()) < exp.size()) && wk < 3000) begin
         @(negedge clk_sys);
         wk++;
      end
      repeat (4) @(negedge clk_sys);
      `CHK("byte count", exp.size(), (from_dev ? wq.size() : hq.size()))
      for (i = 0; i < exp.size(); i++) begin
         if (exp[i] >= 0) `CHK("wire byte", 8'(exp[i]), (from_dev ? wq[i] : hq[i]))
      end
      exp.delete();
      hq.delete();
      if (from_dev) wq.delete();
   endtask: check_msg
   task automatic host_cmd(input logic w, input logic [7:0] sz, input logic [127:0] v);
      cmd_write = w;
      cmd_size = sz;
      cmd_value = v;
      cmd_valid = 1'b1;
      `WAIT_HI(cmd_ack_q)
      cmd_valid = 1'b0;
   endtask: host_cmd
   task automatic serve(input logic ok, input logic [7:0] rs, input logic rok,
                        input logic [127:0] v);
      `WAIT_HI(req_valid_q)
      req_ready = 1'b1;
      @(negedge clk_sys);
      req_ready = 1'b0;
      repeat (3) @(negedge clk_sys);
      {resp_ok, resp_rssi, resp_rssi_ok, resp_value, resp_valid} = {ok, rs, rok, v, 1'b1};
      @(negedge clk_sys);
      resp_valid = 1'b0;
   endtask: serve
   task automatic ev_run(input logic [1:0] role, input int n, input int lim);
      int i;
      node_role_select = role;
      ev_len = 8'(n);
      ev_valid = 1'b1;
      `WAIT_HI(ev_ack_q)
      ev_valid = 1'b0;
      exp = '{8'hFB, 5 + ((n < lim) ? n : lim), 8'h26, 8'hEF, 8'hCD, 8'hAB, 8'h85};
      for (i = 0; i < n; i++) begin
         pl_data = 8'(i + 8'h30);
         pl_valid = 1'b1;
         `WAIT_HI(pl_ready_q)
         @(negedge clk_sys);
         if (i < lim) exp.push_back(i + 8'h30);
      end
      pl_valid = 1'b0;
      check_msg(1);
      `CHK("host ev addr", 24'hABCDEF, msg_addr_q)
   endtask: ev_run
   initial begin
      {cmd_valid, cmd_write, cmd_addr, cmd_offset, cmd_bank, cmd_size, cmd_value} = '0;
      {req_ready, resp_valid, resp_ok, resp_rssi, resp_rssi_ok, resp_value} = '0;
      {ev_valid, ev_rssi_ok, ev_len, pl_valid, pl_data, notice_valid, notice_code} = '0;
      {ev_addr, ev_rssi, node_role_select, bad_count, n_checks, cyc} = {24'hABCDEF, 8'h85, 98'h0};
      rst = 1'b1;
      repeat (20) @(negedge clk_sys);
      rst = 1'b0;
      repeat (2) @(negedge clk_sys);
      ev_rssi_ok = 1'b1;
      {cmd_addr, cmd_offset, cmd_bank} = {24'h123456, 8'h05, 8'h00};
      host_cmd(1'b0, 8'h02, 128'h0);
      serve(1'b1, 8'hF0, 1'b1, 128'hBEEF);
      `CHK("req size", 8'h02, req_size_q)
      `CHK("req addr", 24'h123456, req_addr_q)
      exp = '{8'hFB, 8'h07, 8'h06, 8'h56, 8'h34, 8'h12, 8'h05, 8'h00, 8'h02};
      check_msg(0);
      exp = '{8'hFB, 8'h0B, 8'h16, 8'h00, 8'h56, 8'h34, 8'h12, 8'hF0, 8'h05, 8'h00, 8'h02,
              8'hEF, 8'hBE};
      check_msg(1);
      `CHK("host type", 8'h16, msg_type_q)
      `CHK("host len", 8'h0B, msg_len_q)
      `CHK("host addr", 24'h123456, msg_addr_q)
      host_cmd(1'b0, 8'h02, 128'h0);
      serve(1'b0, 8'h10, 1'b0, 128'h0);
      exp = '{8'hFB, 8'h06, 8'h16, 8'hE1, 8'h56, 8'h34, 8'h12, 8'h7F};
      check_msg(1);
      cmd_offset = 8'h18;
      host_cmd(1'b1, 8'h01, 128'hAA);
      serve(1'b1, 8'h7F, 1'b1, 128'h0);
      `CHK("req value", 8'hAA, req_value_q[7:0])
      `CHK("req write", 1'b1, req_write_q)
      `CHK("req offset", 8'h18, req_offset_q)
      exp = '{8'hFB, 8'h08, 8'h07, 8'h56, 8'h34, 8'h12, 8'h18, 8'h00, 8'h01, 8'hAA};
      check_msg(0);
      exp = '{8'hFB, 8'h06, 8'h17, 8'h00, 8'h56, 8'h34, 8'h12, 8'h7E};
      check_msg(1);
      host_cmd(1'b0, 8'h00, 128'h0);
      exp = '{8'hFB, 8'h06, 8'h16, 8'hE1, 8'h56, 8'h34, 8'h12, 8'h7F};
      check_msg(1);
      `CHK("no request", 1'b0, req_valid_q)
      for (int i = 0; i < 7; i++) begin
         notice_code = (i < 6) ? codes[i] : 8'h55;
         notice_valid = 1'b1;
         `WAIT_HI(notice_ack_q)
         notice_valid = 1'b0;
         if (i < 6) exp = '{8'hFB, 8'h02, 8'h27, codes[i]};
         check_msg(1);
      end
      ev_run(2'h0, 0, 109);
      ev_run(2'h1, 2, 105);
      ev_run(2'h1, 107, 105);
      ev_run(2'h2, 110, 109);
      end_of_test();
   end
endmodule: remote_register_and_event_framer_bench
